// ==== logic/psf_pulse_input.sv ====
/*
  Pulse input speed feedback block: period measurement, frequency
  arithmetic, stall and slip supervision, APB register file.
  Assumes the pulse input is slow enough to be sampled on pclk through a synchroniser.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module psf_pulse_input #(
  parameter int unsigned PERIOD_W    = 24,                // Period bits
  parameter int unsigned TICK_CYCLES = psf_pkg::TICK_CYC  // 0.1 s tick
) (
  input  logic                     pclk,                 // Clock
  input  logic                     presetn,              // Reset, low
  input  psf_pkg::psf_apb_req_type apb_req,              // APB request
  output psf_pkg::psf_apb_rsp_type apb_rsp,              // APB answer
  input  logic                     pulse_input_terminal, // Pulse train
  output psf_pkg::psf_drive_type   drive_out,            // Actions
  output logic [15:0]              feedback_freq,        // 0.01 Hz
  output logic [15:0]              reference_freq        // 0.01 Hz
);
  import psf_pkg::*;

  localparam int DW = 48;

  typedef enum logic [2:0] {
    OP_IDLE, OP_FREQ, OP_FB, OP_REF, OP_LPF
  } psf_op_type;

  typedef struct packed {
    logic                s1, s2, s3;
    logic [PERIOD_W-1:0] cnt, per;
    logic                seen;
    logic [15:0]         tsel, pulses_per_revolution, fbt, a1, b1, a2, b2;
    logic [15:0]         slvl, stim, sact, slip, slt, eact;
    logic [15:0]         rft, ra, rb, lpf, ctrl, maxf, outf;
    logic [31:0]         pfreq;
    logic [15:0]         fbf, reff, filt;
    logic                over, stall, slipf;
    logic [31:0]         tick;
    logic [7:0]          stc, slc;
    psf_op_type          op;
    logic [DW-1:0]       rem, quo, den;
    logic [5:0]          bits;
    logic [31:0]         prdata;
    logic                pready, pslverr;
    psf_drive_type       drv;
  } psf_state_type;

  // ==========================================================
  // Functions
  function automatic logic [2*DW-1:0] div_step(
    input logic [DW-1:0] r, q, d);
    logic [DW:0] t;
    t = {r, q[DW-1]};
    if (t >= {1'b0, d}) begin
      t = t - {1'b0, d};
      return {t[DW-1:0], q[DW-2:0], 1'b1};
    end
    return {t[DW-1:0], q[DW-2:0], 1'b0};
  endfunction

  function automatic logic [15:0] sat16(input logic [DW-1:0] v);
    return (v > DW'(16'hffff)) ? 16'hffff : v[15:0];
  endfunction

  function automatic logic [15:0] adiff(input logic [15:0] a, b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic over_pct(input logic [31:0] v,
                                    input logic [15:0] m, p);
    return (DW'(v) * DW'(PCT_FULL)) > (DW'(m) * DW'(p));
  endfunction

  function automatic logic sel_ok(input logic [15:0] v);
    return (v == SEL_OFF) || (v == SEL_ON);
  endfunction

  function automatic logic [2:0] act_dec(input logic f,
                                         input logic [15:0] c);
    return {f && c == ACT_COAST, f && c == ACT_RAMP, f && c == ACT_WARN};
  endfunction

  function automatic psf_state_type rst_val();
    psf_state_type s;
    s = '0;
    s.pulses_per_revolution = RST_PPR;
    s.a1 = RST_GEAR;
    s.b1 = RST_GEAR;
    s.a2 = RST_GEAR;
    s.b2 = RST_GEAR;
    s.ra = RST_GEAR;
    s.rb = RST_GEAR;
    s.slvl = RST_SLVL;
    s.stim = RST_STIM;
    s.sact = ACT_COAST;
    s.slip = RST_SLIP;
    s.slt = RST_SLT;
    s.eact = ACT_COAST;
    s.lpf = RST_LPF;
    s.maxf = RST_MAXF;
    s.op = OP_IDLE;
    return s;
  endfunction

  localparam psf_state_type ST_RST = rst_val();

  psf_state_type    st;
  psf_state_type    n;
  logic             rise, fb_on, ref_on, tk, setup, acc, wr, hit, wok;
  logic             stall_evt, slip_evt, over_evt;
  logic [31:0]      rd;
  logic [2*DW-1:0]  ds;
  logic [DW-1:0]    q;
  logic [15:0]      w, ga, gb;
  logic [2:0]       clr, a_st, a_sl;

  // ==========================================================
  // Next state
  always_comb begin
    n = st;
    ds = div_step(st.rem, st.quo, st.den);
    q = ds[DW-1:0];
    n.s1 = pulse_input_terminal;
    n.s2 = st.s1;
    n.s3 = st.s2;
    rise = st.s2 & ~st.s3;
    // Only speed feedback and reference exist, no position mode
    ref_on = (st.tsel == SEL_ON) && (st.rft == SEL_ON);
    fb_on = (st.tsel == SEL_ON) && (st.fbt == SEL_ON)
            && (st.rft != SEL_ON) && st.ctrl[CT_VFFB];
    ga = st.ctrl[CT_GEAR2] ? st.a2 : st.a1;
    gb = st.ctrl[CT_GEAR2] ? st.b2 : st.b1;
    over_evt = 1'b0;

    // Saturating counter; a full count means the shaft stands
    if (rise) begin
      // Restart at one so the count at the next edge is the period
      n.cnt = PERIOD_W'(1);
      n.seen = 1'b1;
      if (st.seen) begin
        n.per = st.cnt;
      end
    end else if (st.cnt != '1) begin
      n.cnt = st.cnt + 1'b1;
    end else begin
      n.seen = 1'b0;
      n.per = '0;
      n.pfreq = '0;
      n.fbf = '0;
      n.filt = '0;
      n.reff = '0;
    end

    // One shared divider; an edge arriving while busy is skipped
    unique case (st.op)
      OP_IDLE: begin
        if (rise && st.seen && st.tsel == SEL_ON) begin
          n.op = OP_FREQ;
          n.rem = '0;
          n.quo = DW'(FREQ_K);
          n.den = DW'(st.cnt);
          n.bits = '0;
        end
      end
      OP_FREQ, OP_FB, OP_REF, OP_LPF: begin
        n.rem = ds[2*DW-1:DW];
        n.quo = q;
        n.bits = st.bits + 1'b1;
        if (st.bits == 6'(DW - 1)) begin
          n.op = OP_IDLE;
          n.rem = '0;
          n.bits = '0;
          unique case (st.op)
            OP_FREQ: begin
              n.pfreq = q[31:0];
              over_evt = q > DW'(MAX_CENTI);
              if (fb_on) begin
                n.op = OP_FB;
                n.quo = DW'(q[31:0]) * DW'(ga);
                n.den = DW'(st.pulses_per_revolution) * DW'(gb);
              end else if (ref_on) begin
                n.op = OP_REF;
                n.quo = DW'(q[31:0]) * DW'(st.ra);
                n.den = DW'(st.rb);
              end
            end
            OP_FB: n.fbf = sat16(q);
            OP_REF: begin
              n.filt = sat16(q);
              n.op = OP_LPF;
              n.quo = DW'(adiff(sat16(q), st.reff));
              n.den = DW'(st.lpf);
            end
            OP_LPF: n.reff = (st.filt > st.reff) ? st.reff + q[15:0]
                                                : st.reff - q[15:0];
            OP_IDLE: ;
          endcase
        end
      end
    endcase
    if (!fb_on) begin
      n.fbf = '0;
    end
    if (!ref_on) begin
      n.reff = '0;
      n.filt = '0;
    end

    // Supervision in 0.1 s ticks
    tk = (st.tick == 32'(TICK_CYCLES - 1));
    n.tick = tk ? '0 : st.tick + 1'b1;
    stall_evt = 1'b0;
    slip_evt = 1'b0;
    if (!(fb_on && st.slvl != '0 &&
          over_pct(32'(st.outf), st.maxf, st.slvl))) begin
      n.stc = '0;
    end else if (tk) begin
      if (st.stc > st.stim[7:0]) begin
        stall_evt = 1'b1;
      end else begin
        n.stc = st.stc + 1'b1;
      end
    end
    if (!(fb_on && st.slip != '0 &&
          over_pct(32'(adiff(st.fbf, st.outf)), st.maxf, st.slip))) begin
      n.slc = '0;
    end else if (tk) begin
      if (st.slc > st.slt[7:0]) begin
        slip_evt = 1'b1;
      end else begin
        n.slc = st.slc + 1'b1;
      end
    end

    // APB slave, answers in the first access cycle
    setup = apb_req.psel & ~apb_req.penable;
    acc = apb_req.psel & apb_req.penable & st.pready;
    wr = acc & apb_req.pwrite;
    w = apb_req.pwdata[15:0];
    hit = (apb_req.paddr[1:0] == 2'b00);
    wok = 1'b1;
    rd = '0;
    clr = '0;
    case (apb_req.paddr[13:2])
      IX_TSEL: begin
        rd = 32'(st.tsel);
        wok = sel_ok(w);
        if (wr && wok && hit) n.tsel = w;
      end
      IX_PPR: begin
        rd = 32'(st.pulses_per_revolution);
        wok = (w != '0) && (w <= PPR_MAX);
        if (wr && wok && hit) n.pulses_per_revolution = w;
      end
      IX_FBT: begin
        rd = 32'(st.fbt);
        wok = sel_ok(w) && !(w == SEL_ON && st.rft == SEL_ON);
        if (wr && wok && hit) n.fbt = w;
      end
      IX_A1, IX_B1, IX_A2, IX_B2, IX_RA, IX_RB, IX_LPF: begin
        wok = (w != '0);
        unique case (apb_req.paddr[13:2])
          IX_A1: rd = 32'(st.a1);
          IX_B1: rd = 32'(st.b1);
          IX_A2: rd = 32'(st.a2);
          IX_B2: rd = 32'(st.b2);
          IX_RA: rd = 32'(st.ra);
          IX_RB: rd = 32'(st.rb);
          IX_LPF: rd = 32'(st.lpf);
        endcase
        if (wr && wok && hit) begin
          unique case (apb_req.paddr[13:2])
            IX_A1: n.a1 = w;
            IX_B1: n.b1 = w;
            IX_A2: n.a2 = w;
            IX_B2: n.b2 = w;
            IX_RA: n.ra = w;
            IX_RB: n.rb = w;
            IX_LPF: n.lpf = w;
          endcase
        end
      end
      IX_SLVL: begin
        rd = 32'(st.slvl);
        wok = (w <= SLVL_MAX);
        if (wr && wok && hit) n.slvl = w;
      end
      IX_STIM: begin
        rd = 32'(st.stim);
        wok = (w <= STIM_MAX);
        if (wr && wok && hit) n.stim = w;
      end
      IX_SACT: begin
        rd = 32'(st.sact);
        wok = (w <= ACT_COAST);
        if (wr && wok && hit) n.sact = w;
      end
      IX_SLIP: begin
        rd = 32'(st.slip);
        wok = (w <= SLIP_MAX);
        if (wr && wok && hit) n.slip = w;
      end
      IX_SLT: begin
        rd = 32'(st.slt);
        wok = (w <= SLT_MAX);
        if (wr && wok && hit) n.slt = w;
      end
      IX_EACT: begin
        rd = 32'(st.eact);
        wok = (w <= ACT_COAST);
        if (wr && wok && hit) n.eact = w;
      end
      IX_RFT: begin
        rd = 32'(st.rft);
        wok = sel_ok(w);
        if (wr && wok && hit) n.rft = w;
      end
      IX_CTRL: begin
        rd = 32'(st.ctrl);
        if (wr && hit) n.ctrl = w & CTRL_MASK;
      end
      IX_MAXF: begin
        rd = 32'(st.maxf);
        if (wr && hit) n.maxf = w;
      end
      IX_OUTF: begin
        rd = 32'(st.outf);
        if (wr && hit) n.outf = w;
      end
      IX_PER: begin
        rd = 32'(st.per);
        wok = 1'b0;
      end
      IX_PFRQ: begin
        rd = st.pfreq;
        wok = 1'b0;
      end
      IX_FBF: begin
        rd = 32'(st.fbf);
        wok = 1'b0;
      end
      IX_REFF: begin
        rd = 32'(st.reff);
        wok = 1'b0;
      end
      IX_STAT: begin
        rd[ST_STALL] = st.stall;
        rd[ST_SLIP] = st.slipf;
        rd[ST_OVER] = st.over;
        rd[ST_FB] = fb_on;
        rd[ST_REF] = ref_on;
        if (wr && hit) clr = w[2:0];
      end
      default: hit = 1'b0;
    endcase
    n.pready = setup;
    if (setup) begin
      n.prdata = hit ? rd : '0;
      n.pslverr = ~hit | (apb_req.pwrite & ~wok);
    end

    // Sticky flags: a new event outweighs a clear in the same cycle
    n.stall = (st.stall & ~clr[ST_STALL]) | stall_evt;
    n.slipf = (st.slipf & ~clr[ST_SLIP]) | slip_evt;
    n.over = (st.over & ~clr[ST_OVER]) | over_evt;
    a_st = act_dec(n.stall, st.sact);
    a_sl = act_dec(n.slipf, st.eact);
    n.drv.warn = a_st[0] | a_sl[0];
    n.drv.fault_ramp_stop = a_st[1] | a_sl[1];
    n.drv.fault_coast_stop = a_st[2] | a_sl[2];
    n.drv.fb_active = fb_on;
    n.drv.ref_active = ref_on;
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= n;
    end
  end

  assign apb_rsp.prdata = st.prdata;
  assign apb_rsp.pready = st.pready;
  assign apb_rsp.pslverr = st.pslverr;
  assign drive_out = st.drv;
  assign feedback_freq = st.fbf;
  assign reference_freq = st.reff;

endmodule // psf_pulse_input

// ==== logic/psf_pkg.sv ====
/*
  Constants, register map and carrier types of the pulse input speed
  feedback block. Assumes a 10 MHz APB clock shared with the block.
*/
// Summary of operation
// - Pulse input rated for up to 33 kHz
// - Input routes to feedback or reference use
// - Feedback frequency from time between pulses
// - Single phase: magnitude only, no direction
// - Type select: 0 disabled, 5 enabled
// - Feedback speed only in feedback control mode
// - No position control from pulse commands
// - Resolution 1 to 20000, reset 600
// - Reference gear ratio and low-pass filter
// - Two selectable feedback gear ratio pairs
// - Stall level 0-120%, time 0-2.0 s
// - Slip range 0-50%, time 0-10 s
// - Action fields take one of three codes
// - Stall excess timed, then action taken
// - Actions: warn, ramp stop, coast stop
// - Percentages relative to maximum frequency
package psf_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ   = 10_000_000;
  localparam int unsigned TICK_MS  = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [31:0] FREQ_K   = 32'(CLK_HZ * 100);
  localparam int unsigned MAX_PULSE_HZ = 33_000;
  localparam logic [31:0] MAX_CENTI = 32'(MAX_PULSE_HZ * 100);
  localparam int unsigned PCT_FULL = 100;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [11:0] IX_TSEL  = 12'ha00;
  localparam logic [11:0] IX_PPR   = 12'ha01;
  localparam logic [11:0] IX_FBT   = 12'ha02;
  localparam logic [11:0] IX_A1    = 12'ha04;
  localparam logic [11:0] IX_B1    = 12'ha05;
  localparam logic [11:0] IX_A2    = 12'ha06;
  localparam logic [11:0] IX_B2    = 12'ha07;
  localparam logic [11:0] IX_SLVL  = 12'ha0a;
  localparam logic [11:0] IX_STIM  = 12'ha0b;
  localparam logic [11:0] IX_SACT  = 12'ha0c;
  localparam logic [11:0] IX_SLIP  = 12'ha0d;
  localparam logic [11:0] IX_SLT   = 12'ha0e;
  localparam logic [11:0] IX_EACT  = 12'ha0f;
  localparam logic [11:0] IX_RFT   = 12'ha10;
  localparam logic [11:0] IX_RA    = 12'ha11;
  localparam logic [11:0] IX_RB    = 12'ha12;
  localparam logic [11:0] IX_LPF   = 12'ha15;
  localparam logic [11:0] IX_CTRL  = 12'ha20;
  localparam logic [11:0] IX_MAXF  = 12'ha21;
  localparam logic [11:0] IX_OUTF  = 12'ha22;
  localparam logic [11:0] IX_PER   = 12'ha30;
  localparam logic [11:0] IX_PFRQ  = 12'ha31;
  localparam logic [11:0] IX_FBF   = 12'ha32;
  localparam logic [11:0] IX_REFF  = 12'ha33;
  localparam logic [11:0] IX_STAT  = 12'ha34;

  // ==========================================================
  // Reset values, limits, codes, bit positions
  localparam logic [15:0] RST_PPR    = 16'h0258;
  localparam logic [15:0] RST_GEAR   = 16'h0064;
  localparam logic [15:0] RST_SLVL   = 16'h0073;
  localparam logic [15:0] RST_STIM   = 16'h0001;
  localparam logic [15:0] RST_SLIP   = 16'h0032;
  localparam logic [15:0] RST_SLT    = 16'h0005;
  localparam logic [15:0] RST_LPF    = 16'h0001;
  localparam logic [15:0] RST_MAXF   = 16'h1770;
  localparam logic [15:0] PPR_MAX    = 16'h4e20;
  localparam logic [15:0] SLVL_MAX   = 16'h0078;
  localparam logic [15:0] STIM_MAX   = 16'h0014;
  localparam logic [15:0] SLIP_MAX   = 16'h0032;
  localparam logic [15:0] SLT_MAX    = 16'h0064;
  localparam logic [15:0] SEL_OFF    = 16'h0000;
  localparam logic [15:0] SEL_ON     = 16'h0005;
  localparam logic [15:0] ACT_WARN   = 16'h0000;
  localparam logic [15:0] ACT_RAMP   = 16'h0001;
  localparam logic [15:0] ACT_COAST  = 16'h0002;
  localparam logic [15:0] CTRL_MASK  = 16'h0003;
  localparam int unsigned CT_VFFB    = 0;
  localparam int unsigned CT_GEAR2   = 1;
  localparam int unsigned ST_STALL   = 0;
  localparam int unsigned ST_SLIP    = 1;
  localparam int unsigned ST_OVER    = 2;
  localparam int unsigned ST_FB      = 3;
  localparam int unsigned ST_REF     = 4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } psf_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } psf_apb_rsp_type;

  typedef struct packed {
    logic warn;
    logic fault_ramp_stop;
    logic fault_coast_stop;
    logic fb_active;
    logic ref_active;
  } psf_drive_type;

endpackage

// ==== testbench/psf_pulse_input_monitor.sv ====
/*
  Port checks of the pulse input block, bound to each instance.
  Assumes psf_pkg and a single pclk domain.
*/
`timescale 1ns/100ps
module psf_pulse_input_monitor (
  input wire logic                     pclk,                 // Clock
  input wire logic                     presetn,              // Reset
  input wire psf_pkg::psf_apb_req_type apb_req,              // Request
  input wire psf_pkg::psf_apb_rsp_type apb_rsp,              // Answer
  input wire logic                     pulse_input_terminal, // Pulses
  input wire psf_pkg::psf_drive_type   drive_out,            // Actions
  input wire logic [15:0]              feedback_freq,        // Feedback
  input wire logic [15:0]              reference_freq        // Reference
);
  import psf_pkg::*;
  // ==========================================================
  // Helpers
  logic        wr_acc;
  logic [11:0] idx;
  logic [15:0] wd;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_rsp.pready
                  && apb_req.pwrite;
  assign idx = apb_req.paddr[13:2];
  assign wd = apb_req.pwdata[15:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  chk_ready_setup: assert property (
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  chk_ready_access: assert property (
    apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("ready outside access");
  chk_tsel_codes: assert property (
    wr_acc && idx == IX_TSEL |->
      apb_rsp.pslverr == !(wd == SEL_OFF || wd == SEL_ON))
    else $error("type select code handling wrong");
  chk_ppr_range: assert property (
    wr_acc && idx == IX_PPR |->
      apb_rsp.pslverr == (wd == 16'h0000 || wd > PPR_MAX))
    else $error("resolution range handling wrong");
  chk_use_excl: assert property (
    !(drive_out.fb_active && drive_out.ref_active))
    else $error("both uses active");
  chk_fb_idle_zero: assert property (
    !drive_out.fb_active [*3] |-> feedback_freq == 16'h0000)
    else $error("feedback value outside feedback use");
  chk_ref_idle_zero: assert property (
    !drive_out.ref_active [*3] |-> reference_freq == 16'h0000)
    else $error("reference value outside reference use");
  chk_edge_hold: assert property (
    $rose(pulse_input_terminal) && drive_out.fb_active |=>
      $stable(feedback_freq) [*8])
    else $error("feedback moved before synchroniser delay");
  cover property (drive_out.warn);
  cover property (drive_out.fault_coast_stop);
  cover property (apb_rsp.pready && apb_rsp.pslverr);
  cover property (drive_out.ref_active && reference_freq != 16'h0000);
endmodule // psf_pulse_input_monitor

bind psf_pulse_input psf_pulse_input_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pulse_input_terminal(pulse_input_terminal), .drive_out(drive_out),
  .feedback_freq(feedback_freq), .reference_freq(reference_freq));

// ==== testbench/psf_pulse_source.sv ====
/*
  Single-phase pulse source standing in for the shaft encoder.
  The bench drives up to 50 kHz, above the input's rating, to raise the overrange flag.
*/
`timescale 1ns/100ps
module psf_pulse_source (
  input  wire logic        pclk,        // Clock
  input  wire logic        en,          // Run pulses
  input  wire logic [31:0] half_cycles, // Half period, cycles
  output logic             pulse = 1'b0 // Pulse train
);
  logic [31:0] cnt = 32'h0;
  // Idle low between runs; one phase, no direction info
  always @(posedge pclk) begin
    if (!en) begin
      cnt <= 32'h0;
      pulse <= 1'b0;
    end else if (cnt + 32'h1 >= half_cycles) begin
      cnt <= 32'h0;
      pulse <= ~pulse;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule // psf_pulse_source

// ==== testbench/psf_pulse_input_tb.sv ====
/*
  Self-checking bench of the pulse input block over APB.
  Assumes psf_pkg, the pulse source and the bound monitor.
*/
`timescale 1ns/100ps
module psf_pulse_input_tb;
  import psf_pkg::*;
  logic            pclk;
  logic            presetn;
  psf_apb_req_type req;
  psf_apb_rsp_type rsp;
  logic            src_en;
  logic [31:0]     src_half;
  logic            pulse;
  psf_drive_type   drv;
  logic [15:0]     fb_freq;
  logic [15:0]     ref_freq;
  logic [31:0]     rdv;
  logic            err;
  int              bad_count;
  int              checks_done;

  // Short counts keep timeout and supervision within the run
  psf_pulse_input #(.PERIOD_W(12), .TICK_CYCLES(10)) uut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .pulse_input_terminal(pulse), .drive_out(drv),
    .feedback_freq(fb_freq), .reference_freq(ref_freq));
  psf_pulse_source src (
    .pclk(pclk), .en(src_en), .half_cycles(src_half), .pulse(pulse));

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ix,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, {ix, 2'b00}, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        bad_count++;
        report_and_stop();
      end
    end while (rsp.pready !== 1'b1);
    rdv = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ix, input logic [31:0] wd,
                    input logic exp_err);
    apb(1'b1, ix, wd);
    check(32'(err), 32'(exp_err));
  endtask

  task automatic rd(input logic [11:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    check(rdv, exp);
  endtask

  task automatic run_pulses(input logic [31:0] half, input int cyc);
    src_half <= half;
    src_en <= 1'b1;
    repeat (cyc) @(posedge pclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    check(32'(drv), 32'h0);
    rd(IX_TSEL, 32'h0);
    rd(IX_PPR, 32'h258);
    rd(IX_SACT, 32'h2);
    rd(IX_EACT, 32'h2);
    apb(1'b0, 12'ha03, 32'h0);
    check(32'(err), 32'h1);
  endtask

  task automatic t_field_limits();
    wr(IX_TSEL, 32'h1, 1'b1);
    wr(IX_TSEL, 32'h5, 1'b0);
    rd(IX_TSEL, 32'h5);
    wr(IX_PPR, 32'h0, 1'b1);
    wr(IX_PPR, 32'h4e21, 1'b1);
    wr(IX_PPR, 32'h4e20, 1'b0);
    rd(IX_PPR, 32'h4e20);
    wr(IX_SLVL, 32'h79, 1'b1);
    wr(IX_SLIP, 32'h33, 1'b1);
    wr(IX_SACT, 32'h3, 1'b1);
    wr(IX_A1, 32'h0, 1'b1);
  endtask

  task automatic t_feedback();
    wr(IX_PPR, 32'd100, 1'b0);
    wr(IX_FBT, 32'h5, 1'b0);
    wr(IX_CTRL, 32'h1, 1'b0);
    run_pulses(32'd500, 6000);
    check(32'(drv.fb_active), 32'h1);
    check(32'(fb_freq), 32'd10000);
    // Output frequency left at zero, so the slip supervision trips
    rd(IX_STAT, 32'h0a);
    check(32'(drv.fault_coast_stop), 32'h1);
    rd(IX_PFRQ, 32'd1000000);
    wr(IX_A2, 32'd200, 1'b0);
    wr(IX_CTRL, 32'h3, 1'b0);
    repeat (3000) @(posedge pclk);
    check(32'(fb_freq), 32'd20000);
    src_en <= 1'b0;
    repeat (5000) @(posedge pclk);
    check(32'(fb_freq), 32'h0);
    rd(IX_PER, 32'h0);
  endtask

  task automatic t_stall();
    wr(IX_SLIP, 32'h0, 1'b0);
    wr(IX_STAT, 32'h3, 1'b0);
    wr(IX_STIM, 32'h2, 1'b0);
    wr(IX_SLVL, 32'd100, 1'b0);
    wr(IX_OUTF, 32'd6000, 1'b0);
    repeat (60) @(posedge pclk);
    check(32'({drv.warn, drv.fault_ramp_stop, drv.fault_coast_stop}),
          32'h0);
    for (int code = 0; code < 3; code++) begin
      wr(IX_OUTF, 32'h0, 1'b0);
      wr(IX_STAT, 32'h3, 1'b0);
      wr(IX_SACT, 32'(code), 1'b0);
      wr(IX_OUTF, 32'd7000, 1'b0);
      repeat (12) @(posedge pclk);
      check(32'({drv.warn, drv.fault_ramp_stop, drv.fault_coast_stop}),
            32'h0);
      repeat (60) @(posedge pclk);
      check(32'({drv.warn, drv.fault_ramp_stop, drv.fault_coast_stop}),
            32'h4 >> code);
    end
    wr(IX_OUTF, 32'h0, 1'b0);
    wr(IX_STAT, 32'h3, 1'b0);
  endtask

  task automatic t_reference();
    wr(IX_CTRL, 32'h0, 1'b0);
    wr(IX_FBT, 32'h0, 1'b0);
    wr(IX_RFT, 32'h5, 1'b0);
    wr(IX_FBT, 32'h5, 1'b1);
    wr(IX_RA, 32'd1, 1'b0);
    run_pulses(32'd500, 3000);
    check(32'(drv.ref_active), 32'h1);
    check(32'(drv.fb_active), 32'h0);
    check(32'(fb_freq), 32'h0);
    check(32'(ref_freq), 32'd10000);
    run_pulses(32'd100, 1000);
    src_en <= 1'b0;
    // Let a division still in flight finish before the clear
    repeat (200) @(posedge pclk);
    rd(IX_STAT, 32'h14);
    wr(IX_STAT, 32'h4, 1'b0);
    rd(IX_STAT, 32'h10);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    bad_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    req = '0;
    src_en = 1'b0;
    src_half = 32'd500;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_field_limits();
    t_feedback();
    t_stall();
    t_reference();
    report_and_stop();
  end
endmodule // psf_pulse_input_tb
